/* File: pkg/spi_pkg.sv */
// Constants, field layouts and types for the pointer interpreter.
package spi_pkg;

	// Pointer bytes of one frame as delivered by the upstream framer.
	typedef struct packed {
		logic [7:0] h1;     // First pointer byte: flag, size bits, MSBs.
		logic [7:0] h2;     // Second pointer byte: offset LSBs.
	} spi_ptr_t;

	// Software configuration bits held in the configuration register.
	typedef struct packed {
		logic rdi_insert_enable;        // Alarms request remote defect.
		logic illegal_detect_disable;   // Mutes illegal change detection.
		logic invalid_count_reset_enable; // Accept clears invalid run.
		logic ndf_range_ignore_enable;  // Flag-enabled skips range test.
		logic spacing_check_disable;    // Drops the adjustment spacing.
		logic size_check_disable;       // Drops the size bit check.
	} spi_cfg_t;

	// Interpreter states.
	typedef enum logic [1:0] {
		st_normal,
		st_path_ais,
		pointer_loss_state
	} spi_state_t;

	// Field positions inside the pointer bytes.
	localparam int NDF_MSB   = 7;
	localparam int NDF_LSB   = 4;
	localparam int SS_MSB    = 3;
	localparam int SS_LSB    = 2;

	// Pointer value limits and patterns.
	localparam logic [9:0] MAX_OFFSET   = 10'h30E;  // 782.
	localparam logic [9:0] ZERO_OFFSET  = 10'h000;
	localparam logic [1:0] SS_PATTERN   = 2'h2;     // Binary 10.
	localparam logic [7:0] ALL_ONES     = 8'hFF;

	// Run lengths of the consecutive-indication counters.
	localparam int AIS_RUN      = 3;
	localparam int INV_RUN      = 8;
	localparam int NDF_RUN      = 8;
	localparam int NEWP_RUN     = 3;
	localparam int RUN_W        = 4;
	localparam logic [2:0] ADJ_SPACING = 3'h3;      // Frames.
	localparam logic [1:0] EXIT_LAST   = 2'h2;      // Third frame of exit.

	// Register bus layout.
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] CFG_ADDR    = 3'h0;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 3'h1;
	localparam logic [ADDR_W-1:0] STATE_ADDR  = 3'h2;
	localparam logic [ADDR_W-1:0] OFFSET_ADDR = 3'h3;
	localparam spi_cfg_t CFG_RESET = 6'h00;
	localparam int STATUS_W = 5;

	// Status bit positions (sticky, cleared by reading).
	localparam int ST_INV_NDF  = 0;
	localparam int ST_INV_PTR  = 1;
	localparam int ST_NEW_PTR  = 2;
	localparam int ST_DISCONT  = 3;
	localparam int ST_ILLEGAL  = 4;

endpackage

/* File: src/spi_run_counter.sv */
// Saturating counter of consecutive per-frame indications.
module spi_run_counter #(
	parameter int unsigned W     = 4,
	parameter int unsigned LIMIT = 3
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic         frame,
	input  wire logic         clear,
	input  wire logic         hit,
	input  wire logic         restart,
	output logic [W-1:0]      count,
	output logic              done
);

	// Present run length and its next value.
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         at_limit;

	assign at_limit = (cnt_q == W'(LIMIT));

	// The run completes in the frame that brings the count to its limit.
	assign done = frame & hit & ~restart & (cnt_q == W'(LIMIT - 1));
	assign count = cnt_q;

	// A clear wins; a miss ends the run; a restart begins a new run at one.
	always_comb begin
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = '0;
		end else if (frame) begin
			if (restart) begin
				cnt_d = W'(1);
			end else if (hit) begin
				cnt_d = at_limit ? cnt_q : cnt_q + W'(1);
			end else begin
				cnt_d = '0;
			end
		end
	end

	// Counter register.
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

/* File: src/spi_pointer_interp.sv */
// Receive pointer interpreter with state machine and register port.
//
// Summary of operation
// - Three states, moved by runs of indications.
// - Single valid flag-enabled frame leaves path alarm.
// - Decode five enabled and five disabled flag codes.
// - Other six flag codes report invalid flag.
// - Both pointer bytes all ones means alarm.
// - Normal pointer: disabled flag, size, equal offset.
// - Flag-enabled needs range unless ignored; out of range never stored.
// - Justification needs majority, spacing over three frames.
// - New pointer: in range, differs; invalid unless also justification.
// - Invalid pointer when no other indication.
// - Size bits 10; size and spacing checks optional.
// - Static out-of-range justification withholds pointer loss.
// - Enabled then two disabled equal pointers exit loss.
// - Three identical new pointers replace active offset.
// - Three all-ones frames enter path alarm.
// - Eight invalid or, from normal only, eight flag-enabled enter loss.
// - Justification in normal steps offset, keeps state.
// - Identical new pointers win; optionally clear invalid run.
// - State change clears runs except flag-enabled run.
// - Third identical pointer reports discontinuity; events reported.
// - Early justification flagged illegal; can be disabled.
// - Alarms on outputs; optional remote defect request.
// - Active offset locates overhead; software readable.
module spi_pointer_interp
	import spi_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic                      frame_strobe,
	input  spi_pkg::spi_ptr_t              ptr_bytes,
	input  wire logic [spi_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [spi_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output logic [spi_pkg::DATA_W-1:0]     reg_rdata,
	output logic [9:0]                     active_offset,
	output logic                           offset_valid,
	output logic                           path_alarm_indication,
	output logic                           pointer_loss,
	output logic                           rdi_request
);

	// Returns one for the five enabled new data flag codes.
	function automatic logic ndf_is_enabled(input logic [3:0] code);
		case (code)
			4'h9, 4'h1, 4'hD, 4'hB, 4'h8: ndf_is_enabled = 1'b1;
			default: ndf_is_enabled = 1'b0;
		endcase
	endfunction

	// Returns one for the five disabled new data flag codes.
	function automatic logic ndf_is_disabled(input logic [3:0] code);
		case (code)
			4'h6, 4'hE, 4'h2, 4'h4, 4'h7: ndf_is_disabled = 1'b1;
			default: ndf_is_disabled = 1'b0;
		endcase
	endfunction

	// Returns one when at least three of five bits are set.
	function automatic logic majority5(input logic [4:0] b);
		logic [2:0] sum;
		sum = 3'({2'h0, b[0]}) + 3'({2'h0, b[1]}) + 3'({2'h0, b[2]})
			+ 3'({2'h0, b[3]}) + 3'({2'h0, b[4]});
		majority5 = (sum >= 3'h3);
	endfunction

	// Registers of the interpreter.
	spi_state_t           state_q, state_d;       // Interpreter state.
	logic [9:0]           active_q, active_d;     // Accepted offset.
	logic [9:0]           prev_ptr_q;             // Last received value.
	logic [9:0]           last_new_q;             // Last new pointer value.
	logic [9:0]           cand_q;                 // Loss-exit candidate.
	logic [1:0]           seq_q, seq_d;           // Loss-exit progress.
	logic [2:0]           since_adj_q;            // Frames since adjustment.
	spi_cfg_t             cfg_q;                  // Configuration bits.
	logic [STATUS_W-1:0]  status_q;               // Sticky event bits.
	logic [DATA_W-1:0]    rdata_q;                // Read data register.

	// Fields of the received pointer.
	logic [3:0] ndf;
	logic [1:0] ss;
	logic [9:0] ptr;
	logic [4:0] i_inv, d_inv;
	assign ndf   = ptr_bytes.h1[NDF_MSB:NDF_LSB];
	assign ss    = ptr_bytes.h1[SS_MSB:SS_LSB];
	assign ptr   = {ptr_bytes.h1[1:0], ptr_bytes.h2};
	assign i_inv = {ptr[9], ptr[7], ptr[5], ptr[3], ptr[1]}
		^ {active_q[9], active_q[7], active_q[5], active_q[3], active_q[1]};
	assign d_inv = {ptr[8], ptr[6], ptr[4], ptr[2], ptr[0]}
		^ {active_q[8], active_q[6], active_q[4], active_q[2], active_q[0]};

	// Basic classification of the frame.
	logic ndf_en, ndf_dis, ndf_bad, ss_ok, in_range, same_as_active;
	logic inc_req, dec_req, spaced_raw, spaced;
	assign ndf_en   = ndf_is_enabled(ndf);
	assign ndf_dis  = ndf_is_disabled(ndf);
	assign ndf_bad  = ~ndf_en & ~ndf_dis;
	assign ss_ok    = cfg_q.size_check_disable | (ss == SS_PATTERN);
	assign in_range = (ptr <= MAX_OFFSET);
	assign same_as_active = (ptr == active_q);
	assign inc_req  = majority5(i_inv) & ~majority5(d_inv);
	assign dec_req  = majority5(d_inv) & ~majority5(i_inv);
	// The counter holds the frames passed since the last adjustment frame,
	// less one, so reaching the spacing means more than three frames ago.
	assign spaced_raw = (since_adj_q >= ADJ_SPACING);
	assign spaced   = cfg_q.spacing_check_disable | spaced_raw;

	// Per-frame indications.
	logic norm_point, ndf_enable, all_ones_ind, inc_ind, dec_ind;
	logic new_point, inv_point, lop_hold, illegal_change;
	assign norm_point   = ndf_dis & ss_ok & same_as_active;
	assign ndf_enable   = ndf_en & ss_ok
		& (in_range | cfg_q.ndf_range_ignore_enable);
	assign all_ones_ind = (ptr_bytes.h1 == ALL_ONES)
		& (ptr_bytes.h2 == ALL_ONES);
	assign inc_ind = ndf_dis & ss_ok & inc_req & spaced;
	assign dec_ind = ndf_dis & ss_ok & dec_req & spaced;
	assign new_point = ndf_dis & ss_ok & in_range
		& ~same_as_active;
	// New pointers fall into this set unless they also raise inc_ind or dec_ind.
	assign inv_point = ~(norm_point | ndf_enable | all_ones_ind
		| inc_ind | dec_ind);
	// A static out-of-range justification request does not feed the run.
	assign lop_hold = ~in_range & (ptr == prev_ptr_q)
		& (inc_req | dec_req);
	assign illegal_change = ndf_dis & ss_ok & (inc_req | dec_req)
		& ~spaced_raw & ~cfg_q.illegal_detect_disable;

	// Run counters; a state change clears all but the flag-enabled run.
	logic state_change, clr_inv;
	logic newp_hit, newp_restart, identical_changed_pointer;
	logic ais_done, inv_done, ndf_done;
	logic [RUN_W-1:0] newp_count;
	assign state_change = (state_d != state_q);
	assign newp_hit     = new_point;
	assign newp_restart = new_point & (newp_count != '0)
		& (ptr != last_new_q);
	assign clr_inv = state_change | (identical_changed_pointer
		& cfg_q.invalid_count_reset_enable);

	// Consecutive all-ones frames.
	spi_run_counter #(.W(RUN_W), .LIMIT(AIS_RUN)) u_ais_run (
		.clock   (clock),
		.reset   (reset),
		.frame   (frame_strobe),
		.clear   (state_change),
		.hit     (all_ones_ind),
		.restart (1'b0),
		.count   (),
		.done    (ais_done)
	);

	// Consecutive invalid pointers.
	spi_run_counter #(.W(RUN_W), .LIMIT(INV_RUN)) u_inv_run (
		.clock   (clock),
		.reset   (reset),
		.frame   (frame_strobe),
		.clear   (clr_inv),
		.hit     (inv_point & ~lop_hold),
		.restart (1'b0),
		.count   (),
		.done    (inv_done)
	);

	// Consecutive flag-enabled frames; kept across state changes.
	spi_run_counter #(.W(RUN_W), .LIMIT(NDF_RUN)) u_ndf_run (
		.clock   (clock),
		.reset   (reset),
		.frame   (frame_strobe),
		.clear   (1'b0),
		.hit     (ndf_enable),
		.restart (1'b0),
		.count   (),
		.done    (ndf_done)
	);

	// Consecutive identical new pointers.
	spi_run_counter #(.W(RUN_W), .LIMIT(NEWP_RUN)) u_newp_run (
		.clock   (clock),
		.reset   (reset),
		.frame   (frame_strobe),
		.clear   (state_change),
		.hit     (newp_hit),
		.restart (newp_restart),
		.count   (newp_count),
		.done    (identical_changed_pointer)
	);

	// Loss-exit sequence: flag-enabled, then two disabled, same value.
	logic exit_match, lop_exit;
	assign exit_match = ndf_dis & ss_ok & (ptr == cand_q);
	assign lop_exit = (seq_q == EXIT_LAST) & exit_match;

	// Advances the loss-exit sequence once per frame.
	always_comb begin
		seq_d = seq_q;
		if (frame_strobe) begin
			if (ndf_en & ss_ok & in_range) begin
				seq_d = 2'h1;
			end else if ((seq_q != 2'h0) & exit_match & ~lop_exit) begin
				seq_d = seq_q + 2'h1;
			end else begin
				seq_d = 2'h0;
			end
		end
	end

	// Next state and active offset, evaluated only on the frame strobe.
	always_comb begin
		state_d  = state_q;
		active_d = active_q;
		if (frame_strobe) begin
			if (identical_changed_pointer) begin
				state_d  = st_normal;
				active_d = ptr;
			end else begin
				case (state_q)
					st_normal: begin
						if (ais_done) begin
							state_d = st_path_ais;
						end else if (inv_done | ndf_done) begin
							state_d = pointer_loss_state;
						end else if (ndf_enable & in_range) begin
							active_d = ptr;
						end else if (inc_ind) begin
							active_d = (active_q == MAX_OFFSET) ?
								ZERO_OFFSET : active_q + 10'h001;
						end else if (dec_ind) begin
							active_d = (active_q == ZERO_OFFSET) ?
								MAX_OFFSET : active_q - 10'h001;
						end
					end
					st_path_ais: begin
						if (ndf_enable & in_range) begin
							state_d  = st_normal;
							active_d = ptr;
						end else if (inv_done) begin
							state_d = pointer_loss_state;
						end
					end
					pointer_loss_state: begin
						if (ais_done) begin
							state_d = st_path_ais;
						end else if (lop_exit) begin
							state_d  = st_normal;
							active_d = cand_q;
						end
					end
					default: begin
						state_d = pointer_loss_state;
					end
				endcase
			end
		end
	end

	// State, offset and per-frame history registers.
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q     <= pointer_loss_state;
			active_q    <= ZERO_OFFSET;
			prev_ptr_q  <= ZERO_OFFSET;
			last_new_q  <= ZERO_OFFSET;
			cand_q      <= ZERO_OFFSET;
			seq_q       <= 2'h0;
			since_adj_q <= ADJ_SPACING;  // No adjustment seen yet: spaced.
		end else begin
			state_q <= state_d;
			active_q <= active_d;
			seq_q <= seq_d;
			if (frame_strobe) begin
				prev_ptr_q <= ptr;
				if (new_point) begin
					last_new_q <= ptr;
				end
				if (ndf_en & ss_ok & in_range) begin
					cand_q <= ptr;
				end
				if (ndf_enable | inc_ind | dec_ind) begin
					since_adj_q <= 3'h0;
				end else if (~spaced_raw) begin
					since_adj_q <= since_adj_q + 3'h1;
				end
			end
		end
	end

	// Register decode.
	logic wr_cfg, rd_status;
	assign wr_cfg    = reg_write & (reg_addr == CFG_ADDR);
	assign rd_status = reg_read & (reg_addr == STATUS_ADDR);

	// Events of this frame that set sticky status bits.
	logic [STATUS_W-1:0] status_set;
	assign status_set[ST_INV_NDF] = frame_strobe & ndf_bad;
	assign status_set[ST_INV_PTR] = frame_strobe & inv_point;
	assign status_set[ST_NEW_PTR] = frame_strobe & new_point
		& ~identical_changed_pointer;
	assign status_set[ST_DISCONT] = frame_strobe
		& identical_changed_pointer;
	assign status_set[ST_ILLEGAL] = frame_strobe & illegal_change;

	// Read multiplexer; unmapped addresses read as zero.
	logic [DATA_W-1:0] rd_sel;
	assign rd_sel =
		(reg_addr == CFG_ADDR)    ? DATA_W'(cfg_q) :
		(reg_addr == STATUS_ADDR) ? DATA_W'(status_q) :
		(reg_addr == STATE_ADDR)  ? DATA_W'({pointer_loss,
			path_alarm_indication, state_q}) :
		(reg_addr == OFFSET_ADDR) ? DATA_W'(active_q) :
		'0;

	// Configuration, sticky status and read data registers.
	// A new event in the cycle of a status read survives the clear.
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_q    <= CFG_RESET;
			status_q <= '0;
			rdata_q  <= '0;
		end else begin
			if (wr_cfg) begin
				cfg_q <= spi_cfg_t'(reg_wdata[$bits(spi_cfg_t)-1:0]);
			end
			status_q <= (rd_status ? '0 : status_q) | status_set;
			rdata_q  <= reg_read ? rd_sel : '0;
		end
	end

	// Outputs toward software, alarm port and overhead extraction.
	assign reg_rdata = rdata_q;
	assign active_offset = active_q;
	assign offset_valid  = (state_q == st_normal);
	assign path_alarm_indication = (state_q == st_path_ais);
	assign pointer_loss = (state_q == pointer_loss_state);
	assign rdi_request  = cfg_q.rdi_insert_enable
		& (path_alarm_indication | pointer_loss);

endmodule

/* File: verification/spi_framer_model.sv */
// Behavioural model of the upstream framer feeding pointer bytes.
module spi_framer_model
	import spi_pkg::*;
(
	input  wire logic        clock,
	output spi_pkg::spi_ptr_t ptr_bytes,
	output logic             frame_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// The line is quiet until the first frame arrives.
	initial begin
		frame_strobe = 1'b0;
		ptr_bytes    = 16'h0000;
	end

	// Sends one frame after g+1 idle cycles, so both prompt and slow
	// framing can be produced; outside the strobe the bytes are
	// inverted so a stale pair never passes for a fresh one.
	task automatic send(input logic [15:0] p, input int g);
		repeat (g) @(posedge clock);
		@(posedge clock);
		frame_strobe <= 1'b1;
		ptr_bytes    <= p;
		@(posedge clock);
		frame_strobe <= 1'b0;
		ptr_bytes    <= ~p;
	endtask
endmodule

/* File: verification/spi_pointer_interp_sva.sv */
// Port-level assertions for the pointer interpreter.
module spi_interp_chk
	import spi_pkg::*;
(
	input wire logic                      clock,
	input wire logic                      reset,
	input wire logic                      frame_strobe,
	input spi_pkg::spi_ptr_t              ptr_bytes,
	input wire logic [spi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                      reg_write,
	input wire logic                      reg_read,
	input wire logic [spi_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [9:0]                active_offset,
	input wire logic                      offset_valid,
	input wire logic                      path_alarm_indication,
	input wire logic                      pointer_loss,
	input wire logic                      rdi_request
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] rx_off; // Offset carried by the current pointer bytes.
	logic [9:0] up_off; // One step up, wrapping past the top offset.
	logic [9:0] dn_off; // One step down, wrapping below zero.

	// Decode the received offset and the legal justification steps.
	assign rx_off = {ptr_bytes.h1[1:0], ptr_bytes.h2};
	assign up_off = (active_offset == MAX_OFFSET) ? ZERO_OFFSET :
		active_offset + 10'h001;
	assign dn_off = (active_offset == ZERO_OFFSET) ? MAX_OFFSET :
		active_offset - 10'h001;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_one_state_only: assert property (
		$onehot({offset_valid, path_alarm_indication, pointer_loss}))
		else $error("State outputs are not one-hot.");
	a_quiet_between_frames: assert property (
		!$past(frame_strobe) |-> $stable(active_offset) &&
		$stable({offset_valid, path_alarm_indication, pointer_loss}))
		else $error("State or offset moved without a frame.");
	a_ais_entry_cause: assert property (
		$rose(path_alarm_indication) |->
		$past(frame_strobe) && $past(ptr_bytes) == 16'hFFFF)
		else $error("Path alarm entered without an all-ones frame.");
	a_ais_single_exit: assert property (
		frame_strobe && path_alarm_indication && ptr_bytes == 16'h9A10
		|=> offset_valid && active_offset == 10'h210)
		else $error("Valid enabled frame did not leave path alarm.");
	a_loss_exit_offset: assert property (
		$fell(pointer_loss) && offset_valid |->
		$past(frame_strobe) && active_offset == $past(rx_off))
		else $error("Loss exit did not take the received offset.");
	a_rdi_alarm_only: assert property (
		rdi_request |-> path_alarm_indication || pointer_loss)
		else $error("Remote defect requested without an alarm.");
	a_normal_step: assert property (
		offset_valid && $past(offset_valid) && $changed(active_offset)
		|-> active_offset == $past(up_off) ||
		active_offset == $past(dn_off) || active_offset == $past(rx_off))
		else $error("Offset jumped in normal state.");
	a_rdata_idle: assert property (
		!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("Read data outside a read answer.");
	a_offset_readback: assert property (
		$past(reg_read) && $past(reg_addr) == OFFSET_ADDR |->
		reg_rdata == {6'h00, $past(active_offset)})
		else $error("Offset register disagrees with active offset.");

	// Main scenarios that the bench is expected to reach.
	c_ais_entered: cover property ($rose(path_alarm_indication));
	c_loss_left: cover property ($fell(pointer_loss));
	c_offset_step: cover property (offset_valid && $changed(active_offset));
endmodule

bind spi_pointer_interp spi_interp_chk chk (
	.clock(clock), .reset(reset), .frame_strobe(frame_strobe),
	.ptr_bytes(ptr_bytes), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.active_offset(active_offset), .offset_valid(offset_valid),
	.path_alarm_indication(path_alarm_indication),
	.pointer_loss(pointer_loss), .rdi_request(rdi_request)
);

/* File: verification/spi_pointer_interp_tb.sv */
// Self-checking bench for the pointer interpreter.
module spi_pointer_interp_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_pkg::*;

	logic              clock;         // 50 MHz system clock.
	logic              reset;         // Synchronous reset.
	logic              reg_write;     // Register write strobe.
	logic              reg_read;      // Register read strobe.
	logic              frame_strobe;  // Frame marker from the framer.
	logic [ADDR_W-1:0] reg_addr;      // Register address.
	logic [DATA_W-1:0] reg_wdata;     // Register write data.
	logic [DATA_W-1:0] reg_rdata;     // Register read data.
	spi_ptr_t          ptr_bytes;     // Pointer bytes of the frame.
	logic [9:0]        active_offset; // Accepted payload offset.
	logic              offset_valid;
	logic              path_alarm_indication;
	logic              pointer_loss;
	logic              rdi_request;
	int                n_errors;
	int                total_checks;
	logic [15:0]       junk;          // Discarded read data.
	logic [3:0]        en_c[5]  = '{4'h9, 4'h1, 4'hD, 4'hB, 4'h8};
	logic [3:0]        dis_c[5] = '{4'h6, 4'hE, 4'h2, 4'h4, 4'h7};
	logic [3:0]        bad_c[6] = '{4'h0, 4'h3, 4'h5, 4'hA, 4'hC, 4'hF};

	spi_pointer_interp dut (
		.clock(clock), .reset(reset), .frame_strobe(frame_strobe),
		.ptr_bytes(ptr_bytes), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.active_offset(active_offset), .offset_valid(offset_valid),
		.path_alarm_indication(path_alarm_indication),
		.pointer_loss(pointer_loss), .rdi_request(rdi_request)
	);
	spi_framer_model fr (
		.clock(clock), .ptr_bytes(ptr_bytes),
		.frame_strobe(frame_strobe)
	);

	// Free-running clock of 20 ns period.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// One-cycle read; the answer stands only in the following cycle.
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Reads a register and compares it.
	task automatic rdc(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk(v, e);
	endtask

	// Sends n equal frames with varying idle gaps.
	task automatic frm(input logic [15:0] p, input int n);
		for (int k = 0; k < n; k++) begin
			fr.send(p, k % 3);
		end
		#1;
	endtask

	// Compares {normal, path alarm, loss} and the active offset.
	task automatic st(input logic [2:0] e);
		chk({13'h0000, offset_valid, path_alarm_indication, pointer_loss},
			{13'h0000, e});
	endtask
	task automatic off(input logic [9:0] e);
		chk({6'h00, active_offset}, {6'h00, e});
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		close_out();
	end

	// Main sequence of tests.
	initial begin
		reset     = 1'b1;
		reg_write = 1'b0;
		reg_read  = 1'b0;
		reg_addr  = 3'h0;
		reg_wdata = 16'h0000;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		#1;
		st(3'h1);
		rdc(STATE_ADDR, 16'h000A);
		rdc(CFG_ADDR, 16'h0000);
		rdc(3'h5, 16'h0000);
		wr(CFG_ADDR, 16'h0020);
		rdc(CFG_ADDR, 16'h0020);
		chk({15'h0000, rdi_request}, 16'h0001);
		$display("reset and register test done");
		frm(16'h9A10, 1);
		frm(16'h6A10, 1);
		st(3'h1);
		frm(16'h6A10, 1);
		st(3'h4);
		rdc(OFFSET_ADDR, 16'h0210);
		chk({15'h0000, rdi_request}, 16'h0000);
		rd(STATUS_ADDR, junk);
		$display("pointer loss exit test done");
		frm(16'h6A10, 3);
		frm(16'h6BBA, 1);
		off(10'h211);
		frm(16'h6B44, 1);
		off(10'h211);
		rdc(STATUS_ADDR, 16'h0012);
		rdc(STATUS_ADDR, 16'h0000);
		wr(CFG_ADDR, 16'h0022);
		frm(16'h6B44, 1);
		off(10'h210);
		rd(STATUS_ADDR, junk);
		wr(CFG_ADDR, 16'h0020);
		$display("justification test done");
		frm(16'h6AA0, 2);
		off(10'h210);
		frm(16'h6AA0, 1);
		off(10'h2A0);
		rdc(STATUS_ADDR, 16'h000E);
		$display("new pointer test done");
		for (int i = 0; i < 5; i++) begin
			frm({en_c[i], 12'hAA0}, 1);
			frm({dis_c[i], 12'hAA0}, 1);
		end
		st(3'h4);
		rdc(STATUS_ADDR, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			if (i == 7) begin
				st(3'h4);
			end
			frm({bad_c[i % 6], 12'hAA0}, 1);
		end
		st(3'h1);
		rdc(STATUS_ADDR, 16'h0003);
		$display("flag decode test done");
		frm(16'hFFFF, 2);
		st(3'h1);
		frm(16'hFFFF, 1);
		st(3'h2);
		chk({15'h0000, rdi_request}, 16'h0001);
		rdc(STATE_ADDR, 16'h0005);
		frm(16'h9A10, 1);
		st(3'h4);
		off(10'h210);
		frm(16'h9A10, 6);
		st(3'h4);
		frm(16'h9A10, 1);
		st(3'h1);
		$display("alarm state test done");
		wr(CFG_ADDR, 16'h003D);
		frm(16'h93FF, 1);
		rdc(STATUS_ADDR, 16'h0001);
		frm(16'h9010, 1);
		frm(16'h6010, 2);
		st(3'h4);
		off(10'h010);
		frm(16'h0010, 4);
		frm(16'h60A0, 3);
		off(10'h0A0);
		frm(16'h0010, 1);
		st(3'h4);
		rd(STATUS_ADDR, junk);
		frm(16'h90A0, 1);
		frm(16'h638A, 1);
		off(10'h0A0);
		rdc(STATUS_ADDR, 16'h0002);
		wr(CFG_ADDR, 16'h0030);
		frm(16'h638A, 9);
		st(3'h4);
		$display("option test done");
		close_out();
	end
endmodule
